/* File: rsf_pkg.sv */
`default_nettype none
package rsf_pkg;
  // Timing.
  localparam int RSF_CLK_NS = 25;
  localparam int RSF_MS_NS = 1000000;
  localparam int RSF_MS_CYCLES = (RSF_MS_NS + RSF_CLK_NS - 1) / RSF_CLK_NS;
  // Register byte offsets.
  localparam logic [7:0] RSF_ADR_CMD = 8'h00;
  localparam logic [7:0] RSF_ADR_STATUS = 8'h04;
  localparam logic [7:0] RSF_ADR_CONFIG = 8'h08;
  localparam logic [7:0] RSF_ADR_INTERVAL = 8'h0c;
  localparam logic [7:0] RSF_ADR_STORE = 8'h10;
  localparam logic [7:0] RSF_ADR_VALUE = 8'h14;
  // Status bit positions.
  localparam int RSF_ST_IVL_ERR = 0;
  localparam int RSF_ST_OPT_ERR = 1;
  localparam int RSF_ST_FULL = 2;
  localparam int RSF_ST_ENABLED = 3;
  localparam int RSF_ST_DASHES = 4;
  // Command letters.
  localparam logic [7:0] RSF_CMD_Q = 8'h51;
  localparam logic [7:0] RSF_CMD_I = 8'h49;
  localparam logic [7:0] RSF_CMD_F = 8'h46;
  localparam logic [7:0] RSF_CMD_V = 8'h56;
  localparam logic [7:0] RSF_CMD_C = 8'h43;
  localparam logic [7:0] RSF_CMD_L = 8'h4c;
  localparam logic [7:0] RSF_CMD_G = 8'h47;
  localparam logic [7:0] RSF_CMD_B = 8'h42;
  localparam logic [7:0] RSF_CMD_T = 8'h54;
  localparam logic [7:0] RSF_CMD_X = 8'h58;
  // Argument limits.
  localparam logic [23:0] RSF_IVL_MIN = 24'h00000f;
  localparam logic [23:0] RSF_IVL_MAX = 24'h0f423f;
  localparam logic [23:0] RSF_SIZE_MAX = 24'h0001f4;
  localparam logic [23:0] RSF_FMT_MAX = 24'h000007;
  localparam logic [23:0] RSF_BMODE_MAX = 24'h000002;
  localparam logic [23:0] RSF_TRIG_MAX = 24'h000007;
  localparam logic [23:0] RSF_FUNC_MAX = 24'h000007;
  localparam logic [23:0] RSF_CAL_PT_MAX = 24'h000002;
  localparam logic [23:0] RSF_SETUP_MAX = 24'h000001;
  localparam logic [3:0] RSF_EXP_MAX = 4'h5;
  localparam logic [31:0] RSF_CAL_MAX = 32'h00049f98;
  localparam logic [19:0] RSF_IVL_DEFAULT = 20'h000af;
  localparam int RSF_DEPTH = 500;
  localparam logic [31:0] RSF_NINES = 32'h99999999;
  // Modes.
  localparam logic [2:0] RSF_FUNC_DC_VOLTS = 3'h0;
  localparam logic [1:0] RSF_SRC_CONVERTER = 2'h0;
  localparam logic [1:0] RSF_SRC_SINGLE_RECALL = 2'h1;
  localparam logic [1:0] RSF_SRC_BULK_DUMP = 2'h2;
  localparam logic [1:0] RSF_STIM_TALK = 2'h0;
  localparam logic [1:0] RSF_STIM_GET = 2'h1;
  localparam logic [1:0] RSF_STIM_EXEC = 2'h2;
  localparam logic [1:0] RSF_STIM_PULSE = 2'h3;
  typedef struct packed {
    logic ovf;
    logic [3:0] chan;
    logic [31:0] value;
  } rsf_reading_t;
  typedef struct packed {
    logic term;
    logic prefix;
    logic [8:0] loc;
    logic [3:0] chan;
    logic [31:0] data;
  } rsf_record_t;
  typedef struct packed {
    logic [19:0] ivl;
    logic [8:0] size;
    logic [2:0] fmt;
    logic [2:0] func;
  } rsf_setup_t;
  localparam rsf_setup_t RSF_FACTORY = '{ivl: 20'h000af, size: 9'h000, fmt: 3'h0, func: 3'h0};
endpackage
`default_nettype wire

/* File: rsf_top.sv */
// What this block does
// - Interval argument zero selects 175 ms.
// - Accept intervals 15 to 999999 ms.
// - Interval also paces readings and scans.
// - Continuous modes: start on stimulus, then interval.
// - One-shot modes store one reading per stimulus.
// - Size zero wraps after 500 readings.
// - Size n stops storage after n readings.
// - Size command arms store, shows dashes.
// - Function command disables the store.
// - Interval overrun flags error, stores when possible.
// - Recall and dump work during and after storage.
// - Reset and clear restore interval, size, format.
// - Value takes mantissa and exponent, zeros implied.
// - Calibration commits after last range point.
// - Calibration value above 303000 raises option error.
// - Factory restore reloads and saves defaults.
// - Save records present setup as defaults.
// - Format code picks prefix, location, channel.
// - Source is converter or store by mode.
// - Terminator per reading, once per dump.
// - Absent fields zero, overflow data all nines.
// - Recall walks locations from one, repeats last.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module rsf_top #(
  parameter int P_MS_CYCLES = rsf_pkg::RSF_MS_CYCLES,
  parameter int P_DEPTH = rsf_pkg::RSF_DEPTH
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Bus events and trigger pin.
  input wire logic i_talk,
  input wire logic i_get,
  input wire logic i_dev_clear,
  input wire logic i_ext_trig,
  // Converter readings.
  input wire logic i_rd_valid,
  input wire rsf_pkg::rsf_reading_t i_rd,
  // Output record stream.
  output logic o_out_valid,
  output var rsf_pkg::rsf_record_t o_out_rec,
  input wire logic i_out_ready,
  // Calibration and display.
  output logic o_cal_strobe,
  output logic [1:0] o_cal_point,
  output logic [31:0] o_cal_value,
  output logic o_cal_commit,
  output logic o_disp_dashes,
  output logic o_disp_opt_err,
  output logic o_interval_tick,
  output logic o_store_full
);
  import rsf_pkg::*;

  localparam int MSW = $clog2(P_MS_CYCLES);
  localparam logic [8:0] DEPTH9 = 9'(P_DEPTH);

  typedef enum logic {RSF_IDLE, RSF_EMIT} rsf_out_state_t;

  function automatic logic [31:0] rsf_pow10(input logic [3:0] e);
    logic [31:0] p;
    p = 32'h00000001;
    for (int k = 0; k < 5; k++) begin
      if (4'(k) < e) begin
        p = 32'(p * 32'h0000000a);
      end
    end
    return p;
  endfunction

  function automatic rsf_record_t rsf_mk_rec(input rsf_reading_t r, input logic [8:0] loc,
                                             input logic term, input logic [2:0] fmt);
    rsf_record_t x;
    x.term = term;
    x.prefix = ~fmt[0];
    x.loc = fmt[1] ? loc : 9'h000;
    x.chan = fmt[2] ? r.chan : 4'h0;
    x.data = r.ovf ? RSF_NINES : r.value;
    return x;
  endfunction

  logic rst_meta_q, rst_n_q, rst_n;
  logic ext_s1_q, ext_s2_q, ext_s3_q, ext_rise;
  rsf_setup_t setup_q, saved_q;
  logic [2:0] trig_q;
  logic [1:0] bmode_q;
  logic store_en_q, started_q, dashes_q, pend_q;
  logic [8:0] count_q, wr_ptr_q, rcl_q, idx_q;
  logic [MSW-1:0] ms_cnt_q;
  logic [19:0] ivl_cnt_q;
  logic ms_tick, ivl_due, ivl_tick_q;
  logic err_ivl_q, err_opt_q;
  logic [31:0] value_q;
  logic value_ok_q;
  logic cal_strobe_q, cal_commit_q;
  logic [1:0] cal_point_q;
  logic [31:0] cal_value_q;
  rsf_reading_t mem [0:P_DEPTH-1];
  rsf_reading_t last_rd_q;
  logic has_rd_q;
  rsf_out_state_t ost_q;
  logic out_valid_q;
  rsf_record_t out_rec_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic store_full_q;
  logic wb_req, cmd_wr, opt_bad, cmd_ok;
  logic [7:0] letter;
  logic [23:0] arg;
  logic c_q, c_i, c_f, c_v, c_c, c_l, c_g, c_b, c_t, c_x;
  logic stim, one_shot, full, can_store, store_now, pend_set, overrun;
  logic [51:0] vprod;
  logic [31:0] rmux;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_n_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_trig;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_rise = ext_s2_q & ~ext_s3_q;

  // Command decode; one command per full-word write, rejected options change nothing.
  assign wb_req = i_wb_cyc & i_wb_stb & ~ack_q;
  assign cmd_wr = wb_req & i_wb_we & (i_wb_adr == RSF_ADR_CMD) & (i_wb_sel == 4'hf);
  assign letter = i_wb_dat[31:24];
  assign arg = i_wb_dat[23:0];
  always_comb begin
    opt_bad = 1'b0;
    case (letter)
      RSF_CMD_Q: opt_bad = (arg != 24'h000000) && (arg < RSF_IVL_MIN || arg > RSF_IVL_MAX);
      RSF_CMD_I: opt_bad = arg > RSF_SIZE_MAX;
      RSF_CMD_F: opt_bad = arg > RSF_FUNC_MAX;
      RSF_CMD_V: opt_bad = arg[23:20] > RSF_EXP_MAX;
      RSF_CMD_C: opt_bad = (arg > RSF_CAL_PT_MAX) || !value_ok_q || (value_q > RSF_CAL_MAX);
      RSF_CMD_L: opt_bad = arg > RSF_SETUP_MAX;
      RSF_CMD_G: opt_bad = arg > RSF_FMT_MAX;
      RSF_CMD_B: opt_bad = arg > RSF_BMODE_MAX;
      RSF_CMD_T: opt_bad = arg > RSF_TRIG_MAX;
      RSF_CMD_X: opt_bad = 1'b0;
      default: opt_bad = 1'b1;
    endcase
  end
  assign cmd_ok = cmd_wr & ~opt_bad;
  assign c_q = cmd_ok & (letter == RSF_CMD_Q);
  assign c_i = cmd_ok & (letter == RSF_CMD_I);
  assign c_f = cmd_ok & (letter == RSF_CMD_F);
  assign c_v = cmd_ok & (letter == RSF_CMD_V);
  assign c_c = cmd_ok & (letter == RSF_CMD_C);
  assign c_l = cmd_ok & (letter == RSF_CMD_L);
  assign c_g = cmd_ok & (letter == RSF_CMD_G);
  assign c_b = cmd_ok & (letter == RSF_CMD_B);
  assign c_t = cmd_ok & (letter == RSF_CMD_T);
  assign c_x = cmd_ok & (letter == RSF_CMD_X);

  // Setup. Saved defaults live in flops here, so a power cycle returns to factory values.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= RSF_FACTORY;
      saved_q <= RSF_FACTORY;
    end else if (i_dev_clear) begin
      setup_q.ivl <= saved_q.ivl;
      setup_q.size <= saved_q.size;
      setup_q.fmt <= saved_q.fmt;
    end else begin
      if (c_q) begin
        setup_q.ivl <= (arg == 24'h000000) ? RSF_IVL_DEFAULT : arg[19:0];
      end
      if (c_i) begin
        setup_q.size <= arg[8:0];
      end
      if (c_g) begin
        setup_q.fmt <= arg[2:0];
      end
      if (c_f) begin
        setup_q.func <= arg[2:0];
      end
      if (c_l && arg[0]) begin
        saved_q <= setup_q;
      end
      if (c_l && !arg[0]) begin
        setup_q <= RSF_FACTORY;
        saved_q <= RSF_FACTORY;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 3'h0;
      bmode_q <= RSF_SRC_CONVERTER;
    end else if (i_dev_clear) begin
      trig_q <= 3'h0;
      bmode_q <= RSF_SRC_CONVERTER;
    end else begin
      if (c_t) begin
        trig_q <= arg[2:0];
      end
      if (c_b) begin
        bmode_q <= arg[1:0];
      end
    end
  end

  // Stimulus of the selected trigger pair; odd codes are the one-shot modes.
  always_comb begin
    case (trig_q[2:1])
      RSF_STIM_TALK: stim = i_talk;
      RSF_STIM_GET: stim = i_get;
      RSF_STIM_EXEC: stim = c_x;
      RSF_STIM_PULSE: stim = ext_rise;
      default: stim = 1'b0;
    endcase
  end
  assign one_shot = trig_q[0];

  // Millisecond divider and interval counter; the interval restarts at the first stimulus.
  assign ms_tick = (ms_cnt_q == MSW'(P_MS_CYCLES - 1));
  assign ivl_due = ms_tick && (ivl_cnt_q + 20'h00001 >= setup_q.ivl);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
      ivl_cnt_q <= 20'h00000;
      ivl_tick_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : MSW'(ms_cnt_q + 1'b1);
      ivl_tick_q <= ivl_due;
      if (stim && store_en_q && !started_q && !one_shot) begin
        ivl_cnt_q <= 20'h00000;
      end else if (ivl_due) begin
        ivl_cnt_q <= 20'h00000;
      end else if (ms_tick) begin
        ivl_cnt_q <= ivl_cnt_q + 20'h00001;
      end
    end
  end

  // Storage requests. A request still waiting at the next interval is an overrun;
  // the reading then goes in as soon as the converter delivers one.
  assign full = (setup_q.size != 9'h000) && (count_q == setup_q.size);
  assign can_store = store_en_q & ~full;
  assign store_now = pend_q & i_rd_valid & can_store;
  assign pend_set = store_en_q & (one_shot ? stim :
                    ((stim & ~started_q) | (started_q & ivl_due)));
  assign overrun = store_en_q & ~one_shot & started_q & ivl_due & pend_q & ~store_now;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_en_q <= 1'b0;
      started_q <= 1'b0;
      dashes_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (i_dev_clear) begin
      store_en_q <= 1'b0;
      started_q <= 1'b0;
      dashes_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (c_i) begin
      store_en_q <= 1'b1;
      started_q <= 1'b0;
      dashes_q <= 1'b1;
      pend_q <= 1'b0;
    end else if (c_f) begin
      store_en_q <= 1'b0;
      dashes_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (stim && store_en_q) begin
        started_q <= 1'b1;
        dashes_q <= 1'b0;
      end
      pend_q <= can_store & (pend_set | (pend_q & ~store_now));
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 9'h000;
      wr_ptr_q <= 9'h000;
    end else if (c_i) begin
      count_q <= 9'h000;
      wr_ptr_q <= 9'h000;
    end else if (store_now) begin
      wr_ptr_q <= (wr_ptr_q == DEPTH9 - 9'h001) ? 9'h000 : wr_ptr_q + 9'h001;
      if (count_q != DEPTH9) begin
        count_q <= count_q + 9'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (store_now) begin
      mem[wr_ptr_q] <= i_rd;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_rd_q <= '0;
      has_rd_q <= 1'b0;
    end else if (i_rd_valid) begin
      last_rd_q <= i_rd;
      has_rd_q <= 1'b1;
    end
  end

  // Error flags: a new error in the clearing cycle survives the clear.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_ivl_q <= 1'b0;
      err_opt_q <= 1'b0;
    end else begin
      err_ivl_q <= overrun | (err_ivl_q & ~(wb_req & i_wb_we & (i_wb_adr == RSF_ADR_STATUS) &
                                             i_wb_sel[0] & i_wb_dat[RSF_ST_IVL_ERR]));
      err_opt_q <= (cmd_wr & opt_bad) | (err_opt_q & ~(wb_req & i_wb_we & (i_wb_adr == RSF_ADR_STATUS) &
                                                       i_wb_sel[0] & i_wb_dat[RSF_ST_OPT_ERR]));
    end
  end

  // Value and calibration.
  assign vprod = i_wb_dat[19:0] * rsf_pow10(i_wb_dat[23:20]);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= 32'h00000000;
      value_ok_q <= 1'b0;
      cal_strobe_q <= 1'b0;
      cal_commit_q <= 1'b0;
      cal_point_q <= 2'h0;
      cal_value_q <= 32'h00000000;
    end else begin
      cal_strobe_q <= c_c;
      cal_commit_q <= c_c && ((arg[1:0] == 2'h2) ||
                      ((arg[1:0] == 2'h1) && (setup_q.func != RSF_FUNC_DC_VOLTS)));
      if (c_v) begin
        value_q <= vprod[31:0];
        value_ok_q <= 1'b1;
      end
      if (c_c) begin
        cal_point_q <= arg[1:0];
        cal_value_q <= value_q;
      end
    end
  end

  // Output records, one per talk request, or the whole store back to back in dump mode.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_q <= RSF_IDLE;
      out_valid_q <= 1'b0;
      out_rec_q <= '0;
      rcl_q <= 9'h000;
      idx_q <= 9'h000;
    end else begin
      if (c_b || c_i || i_dev_clear) begin
        rcl_q <= 9'h000;
      end
      case (ost_q)
        RSF_IDLE: begin
          if (i_talk) begin
            if (bmode_q == RSF_SRC_CONVERTER && has_rd_q) begin
              out_rec_q <= rsf_mk_rec(last_rd_q, 9'h000, 1'b1, setup_q.fmt);
              out_valid_q <= 1'b1;
              ost_q <= RSF_EMIT;
            end else if (bmode_q == RSF_SRC_SINGLE_RECALL && count_q != 9'h000) begin
              out_rec_q <= rsf_mk_rec(mem[rcl_q], rcl_q + 9'h001, 1'b1, setup_q.fmt);
              out_valid_q <= 1'b1;
              ost_q <= RSF_EMIT;
              if (rcl_q + 9'h001 < count_q) begin
                rcl_q <= rcl_q + 9'h001;
              end
            end else if (bmode_q == RSF_SRC_BULK_DUMP && count_q != 9'h000) begin
              out_rec_q <= rsf_mk_rec(mem[0], 9'h001, count_q == 9'h001, setup_q.fmt);
              out_valid_q <= 1'b1;
              idx_q <= 9'h001;
              ost_q <= RSF_EMIT;
            end
          end
        end
        RSF_EMIT: begin
          if (i_out_ready) begin
            if (!out_rec_q.term && idx_q < count_q) begin
              out_rec_q <= rsf_mk_rec(mem[idx_q], idx_q + 9'h001, idx_q + 9'h001 == count_q,
                                      setup_q.fmt);
              idx_q <= idx_q + 9'h001;
            end else begin
              out_valid_q <= 1'b0;
              ost_q <= RSF_IDLE;
            end
          end
        end
        default: begin
          out_valid_q <= 1'b0;
          ost_q <= RSF_IDLE;
        end
      endcase
    end
  end

  // Wishbone: ack one cycle after the request; unmapped reads return zero.
  always_comb begin
    case (i_wb_adr)
      RSF_ADR_STATUS: rmux = {27'h0000000, dashes_q, store_en_q, full, err_opt_q, err_ivl_q};
      RSF_ADR_CONFIG: rmux = {21'h000000, trig_q, bmode_q, setup_q.fmt, setup_q.func};
      RSF_ADR_INTERVAL: rmux = {12'h000, setup_q.ivl};
      RSF_ADR_STORE: rmux = {7'h00, count_q, 7'h00, setup_q.size};
      RSF_ADR_VALUE: rmux = value_q;
      default: rmux = 32'h00000000;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !i_wb_we) begin
        rdat_q <= rmux;
      end
    end
  end

  assign o_wb_dat = rdat_q;
  assign o_wb_ack = ack_q;
  assign o_out_valid = out_valid_q;
  assign o_out_rec = out_rec_q;
  assign o_cal_strobe = cal_strobe_q;
  assign o_cal_point = cal_point_q;
  assign o_cal_value = cal_value_q;
  assign o_cal_commit = cal_commit_q;
  assign o_disp_dashes = dashes_q;
  assign o_disp_opt_err = err_opt_q;
  assign o_interval_tick = ivl_tick_q;
  assign o_store_full = store_full_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_full_q <= 1'b0;
    end else begin
      store_full_q <= store_en_q & full;
    end
  end
endmodule
`default_nettype wire

/* File: rsf_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rsf_assertions #(
  parameter int P_MS_CYCLES = 4
) (
  // Clock, reset and bus.
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  // Records, calibration and store state.
  input wire logic i_out_ready,
  input wire logic o_out_valid,
  input wire rsf_pkg::rsf_record_t o_out_rec,
  input wire logic o_cal_strobe,
  input wire logic [31:0] o_cal_value,
  input wire logic o_cal_commit,
  input wire logic o_disp_dashes,
  input wire logic o_store_full,
  input wire logic o_interval_tick
);
  import rsf_pkg::*;
  logic [31:0] gap_q;
  logic cal_take_q;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_cmd(logic [7:0] l, logic [23:0] lim);
    i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel == 4'hf && i_wb_adr == RSF_ADR_CMD
      && i_wb_dat[31:24] == l && i_wb_dat[23:0] <= lim;
  endsequence
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // Cycles since the last tick.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_q <= 32'h0;
    end else begin
      gap_q <= o_interval_tick ? 32'h0 : gap_q + 32'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_take_q <= 1'b0;
    end else begin
      cal_take_q <= i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == RSF_ADR_CMD
        && i_wb_sel == 4'hf && i_wb_dat[31:24] == RSF_CMD_C;
    end
  end
  chk_bus_answer: assert property (s_req |=> o_wb_ack)
    else $error("no ack");
  chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  chk_record_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_rec))
    else $error("record changed");
  chk_loc_range: assert property (o_out_valid |-> o_out_rec.loc <= 9'h1f4)
    else $error("location out of range");
  chk_size_arms: assert property (s_cmd(RSF_CMD_I, RSF_SIZE_MAX) |-> ##[1:2] (o_disp_dashes && !o_store_full))
    else $error("store not armed");
  chk_func_disarms: assert property (s_cmd(RSF_CMD_F, RSF_FUNC_MAX) |-> ##[1:2] (!o_disp_dashes && !o_store_full))
    else $error("store left armed");
  chk_cal_cause: assert property (o_cal_strobe |-> cal_take_q)
    else $error("stray cal point");
  chk_cal_limit: assert property (o_cal_strobe |-> o_cal_value <= RSF_CAL_MAX)
    else $error("cal value too big");
  chk_commit_pair: assert property (o_cal_commit |-> o_cal_strobe)
    else $error("stray commit");
  chk_tick_gap: assert property (o_interval_tick |-> gap_q >= 14 * P_MS_CYCLES)
    else $error("ticks too close");
endmodule
bind rsf_top rsf_assertions #(.P_MS_CYCLES(P_MS_CYCLES)) u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
  .i_out_ready(i_out_ready), .o_out_valid(o_out_valid), .o_out_rec(o_out_rec), .o_cal_strobe(o_cal_strobe),
  .o_cal_value(o_cal_value), .o_cal_commit(o_cal_commit), .o_disp_dashes(o_disp_dashes),
  .o_store_full(o_store_full), .o_interval_tick(o_interval_tick));
`default_nettype wire

/* File: rsf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsf_host_model (
  // Clock and stall control.
  input wire logic i_clk,
  input wire logic i_stall,
  // Record stream.
  input wire logic i_valid,
  input wire rsf_pkg::rsf_record_t i_rec,
  output logic o_ready,
  output var rsf_pkg::rsf_record_t o_last,
  output int o_count
);
  import rsf_pkg::*;
  // A stall only withholds acceptance, so the device must keep offering the same record.
  assign o_ready = !i_stall;
  initial o_count = 0;
  always @(posedge i_clk) begin
    if (i_valid === 1'b1 && o_ready) begin
      o_last <= i_rec;
      o_count <= o_count + 1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rsf_pkg::*;
  localparam int MS = 4;
  typedef struct {
    logic [7:0] l;
    logic [23:0] arg;
    logic [7:0] a;
    logic [31:0] m;
    logic [31:0] e;
  } rsf_row_t;
  logic clk = 1'b0;
  logic rst_n, cyc, stb, we, talk, get, dclr, rdv, stall, ack, ovalid, ready, cstb, full;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  rsf_reading_t rd;
  rsf_record_t rec, last;
  int errors = 0;
  int checks = 0;
  int ncal = 0;
  int hcount;
  rsf_row_t rows[11] = '{
    '{RSF_CMD_Q, 24'h0, RSF_ADR_INTERVAL, 32'hfffff, 32'haf},
    '{RSF_CMD_Q, 24'hf, RSF_ADR_INTERVAL, 32'hfffff, 32'hf},
    '{RSF_CMD_Q, 24'hf423f, RSF_ADR_INTERVAL, 32'hfffff, 32'hf423f},
    '{RSF_CMD_Q, 24'he, RSF_ADR_INTERVAL, 32'hfffff, 32'hf423f},
    '{RSF_CMD_G, 24'h3, RSF_ADR_CONFIG, 32'h38, 32'h18},
    '{RSF_CMD_G, 24'h7, RSF_ADR_CONFIG, 32'h38, 32'h38},
    '{RSF_CMD_B, 24'h2, RSF_ADR_CONFIG, 32'hc0, 32'h80},
    '{RSF_CMD_T, 24'h5, RSF_ADR_CONFIG, 32'h700, 32'h500},
    '{RSF_CMD_F, 24'h4, RSF_ADR_CONFIG, 32'h7, 32'h4},
    '{RSF_CMD_I, 24'h1f4, RSF_ADR_STORE, 32'h1ff, 32'h1f4},
    '{RSF_CMD_I, 24'h0, RSF_ADR_STORE, 32'h1ff, 32'h0}};
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    ncal <= ncal + ((cstb === 1'b1) ? 1 : 0);
  end
  rsf_top #(.P_MS_CYCLES(MS), .P_DEPTH(RSF_DEPTH)) uut (
    .i_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_talk(talk), .i_get(get),
    .i_dev_clear(dclr), .i_ext_trig(1'b0), .i_rd_valid(rdv), .i_rd(rd), .o_out_valid(ovalid),
    .o_out_rec(rec), .i_out_ready(ready), .o_cal_strobe(cstb), .o_cal_point(), .o_cal_value(),
    .o_cal_commit(), .o_disp_dashes(), .o_disp_opt_err(), .o_interval_tick(), .o_store_full(full));
  rsf_host_model host (.i_clk(clk), .i_stall(stall), .i_valid(ovalid), .i_rec(rec), .o_ready(ready),
    .o_last(last), .o_count(hcount));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] l, input logic [23:0] arg);
    wb(1'b1, RSF_ADR_CMD, {l, arg});
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    talk <= (k == 0);
    get <= (k == 1);
    dclr <= (k == 2);
    @(posedge clk);
    talk <= 1'b0;
    get <= 1'b0;
    dclr <= 1'b0;
  endtask
  task automatic reading(input logic o, input logic [31:0] v);
    @(posedge clk);
    rdv <= 1'b1;
    rd <= '{ovf: o, chan: 4'h3, value: v};
    @(posedge clk);
    rdv <= 1'b0;
  endtask
  task automatic fetch(input logic t, input int n);
    if (t) begin
      pulse(0);
    end
    for (int k = 0; k < 40 && hcount < n; k++) begin
      @(posedge clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {rst_n, cyc, stb, we, talk, get, dclr, rdv, stall} = '0;
    adr = 8'h00;
    wdat = 32'h0;
    rd = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, RSF_ADR_INTERVAL, 32'h0);
    chk(q, 32'haf, "reset ivl");
    foreach (rows[i]) begin
      cmd(rows[i].l, rows[i].arg);
      wb(1'b0, rows[i].a, 32'h0);
      chk(q & rows[i].m, rows[i].e, "register row");
    end
    cmd(RSF_CMD_G, 24'h6);
    cmd(RSF_CMD_T, 24'h3);
    cmd(RSF_CMD_I, 24'h2);
    wb(1'b0, RSF_ADR_STATUS, 32'h0);
    chk(q[4:3], 2'h3, "armed");
    for (int k = 0; k < 3; k++) begin
      pulse(1);
      reading(k == 1, 32'h00012345 + k);
    end
    wb(1'b0, RSF_ADR_STORE, 32'h0);
    chk(q[24:16], 9'h002, "count");
    chk(full, 1'b1, "store full");
    cmd(RSF_CMD_B, 24'h1);
    for (int k = 1; k <= 3; k++) begin
      fetch(1'b1, k);
      chk(last.loc, (k > 2) ? 9'h002 : 9'(k), "recall loc");
    end
    chk(last.data, RSF_NINES, "nines");
    chk({last.term, last.prefix}, 2'h3, "term");
    cmd(RSF_CMD_B, 24'h2);
    stall <= 1'b1;
    pulse(0);
    repeat (3) @(posedge clk);
    chk({ovalid, rec.term, rec.loc}, {2'b10, 9'h001}, "held rec");
    stall <= 1'b0;
    fetch(1'b0, 5);
    chk({last.term, last.loc}, {1'b1, 9'h002}, "dump end");
    repeat (4) @(posedge clk);
    chk(hcount, 5, "records");
    cmd(RSF_CMD_I, 24'h0);
    for (int k = 1; k <= 501; k++) begin
      pulse(1);
      reading(1'b0, k);
    end
    chk(full, 1'b0, "wrap full");
    cmd(RSF_CMD_B, 24'h1);
    fetch(1'b1, 6);
    chk(last.data, 32'h1f5, "wrap data");
    cmd(RSF_CMD_Q, 24'hf);
    cmd(RSF_CMD_T, 24'h0);
    cmd(RSF_CMD_B, 24'h0);
    cmd(RSF_CMD_I, 24'h0);
    wb(1'b1, RSF_ADR_STATUS, 32'h3);
    rdv <= 1'b1;
    pulse(0);
    repeat (3 * 15 * MS + 10) @(posedge clk);
    rdv <= 1'b0;
    wb(1'b0, RSF_ADR_STORE, 32'h0);
    chk(q[24:16], 9'h004, "paced");
    wb(1'b0, RSF_ADR_STATUS, 32'h0);
    chk(q[0], 1'b0, "no overrun");
    repeat (130) @(posedge clk);
    wb(1'b0, RSF_ADR_STATUS, 32'h0);
    chk(q[0], 1'b1, "overrun");
    cmd(RSF_CMD_F, 24'h0);
    wb(1'b0, RSF_ADR_STATUS, 32'h0);
    chk(q[3], 1'b0, "disabled");
    cmd(RSF_CMD_Q, 24'h64);
    cmd(RSF_CMD_L, 24'h1);
    cmd(RSF_CMD_Q, 24'hc8);
    pulse(2);
    wb(1'b0, RSF_ADR_INTERVAL, 32'h0);
    chk(q, 32'h64, "saved");
    cmd(RSF_CMD_L, 24'h0);
    pulse(2);
    wb(1'b0, RSF_ADR_INTERVAL, 32'h0);
    chk(q, 32'haf, "factory");
    cmd(RSF_CMD_V, 24'h40001e);
    wb(1'b0, RSF_ADR_VALUE, 32'h0);
    chk(q, 32'h493e0, "value");
    cmd(RSF_CMD_C, 24'h0);
    cmd(RSF_CMD_V, 24'h49f99);
    cmd(RSF_CMD_C, 24'h1);
    wb(1'b0, RSF_ADR_STATUS, 32'h0);
    chk(q[1], 1'b1, "opt err");
    cmd(RSF_CMD_V, 24'h0);
    cmd(RSF_CMD_C, 24'h2);
    repeat (2) @(posedge clk);
    chk(ncal, 2, "cal points");
    tally_and_finish();
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
